// file: rtl/ics_consts.vh
// Purpose: Constants for the interrupt gating and context shadow block.
// Assumes: APB byte offsets, 8-bit registers in the low bits of each word.
// Notes:   Shadow copies sit in a window reached as bank 31 by the core.
`ifndef ICS_CONSTS_VH
`define ICS_CONSTS_VH

// Register byte offsets.
`define ICS_OFF_IRQ_CONTROL   8'h00
`define ICS_OFF_PERIPH_EN_ONE 8'h04
`define ICS_OFF_CONFIG        8'h08
`define ICS_OFF_STATE         8'h0C
`define ICS_OFF_SHADOW_BASE   8'h20
`define ICS_SHADOW_COUNT      6

// irq_control bit positions.
`define ICS_GIE_BIT           7
`define ICS_PERIPH_IRQ_ENABLE_BIT          6
`define ICS_T0IE_BIT          5
`define ICS_EXTIE_BIT         4
`define ICS_PCIE_BIT          3
`define ICS_T0IF_BIT          2
`define ICS_EXTIF_BIT         1
`define ICS_PCIF_BIT          0

// Shadow slot indices.
`define ICS_SH_W              0
`define ICS_SH_STATUS         1
`define ICS_SH_BANK           2
`define ICS_SH_FSR_LO         3
`define ICS_SH_FSR_HI         4
`define ICS_SH_PCLATCH        5

// Status bits that are never saved: watchdog expiry and sleep entry.
`define ICS_STATUS_SAVE_MASK  8'hE7

// Reset values and vector.
`define ICS_RST_IRQ_CONTROL   8'h00
`define ICS_RST_PERIPH_EN_ONE 8'h00
`define ICS_RST_CONFIG        8'h00
`define ICS_VECTOR            15'h0004

`endif

// file: rtl/ics_edge_det.v
// Purpose: Selectable edge detector for the external interrupt pin.
// Assumes: Pin input is already synchronous to the clock.
// Notes:   Emits a one-cycle pulse on the selected edge.
`timescale 1ns/1ns
module ics_edge_det (
   // Clock and reset
   input  wire clk_in,
   input  wire rst_in,
   input  wire ce_in,
   // Pin and selection
   input  wire pin_in,
   input  wire rising_in,
   // Result
   output reg  edge_out
);

   reg prev;

   always @(posedge clk_in) begin
      if (rst_in) begin
         prev     <= 1'b0;
         edge_out <= 1'b0;
      end else if (ce_in) begin
         prev <= pin_in;
         if (rising_in) begin
            edge_out <= pin_in & ~prev;
         end else begin
            edge_out <= ~pin_in & prev;
         end
      end
   end

endmodule

// file: rtl/ics_ctrl.v
// Purpose: Interrupt gating, vectoring and automatic context shadowing.
// Assumes: APB slave with 32-bit data; core events are synchronous.
// Notes:   Core sequencing is a small state machine: entry, vector, service.
`timescale 1ns/1ns
`include "ics_consts.vh"

module ics_ctrl #(
   parameter PC_WIDTH = 15
) (
   // Clock, reset and enable
   input  wire                CLK_IN,
   input  wire                SYS_RST_IN,
   input  wire                CE_IN,
   // APB slave
   input  wire                PSEL_IN,
   input  wire                PENABLE_IN,
   input  wire                PWRITE_IN,
   input  wire [7:0]          PADDR_IN,
   input  wire [31:0]         PWDATA_IN,
   output reg                 PREADY_OUT,
   output reg  [31:0]         PRDATA_OUT,
   output reg                 PSLVERR_OUT,
   // Interrupt sources
   input  wire                TIMER0_COUNT_OVF_IN,
   input  wire                EXT_PIN_IN,
   input  wire                PIN_CHANGE_ANY_IN,
   input  wire [7:0]          PERIPH_FLAGS_IN,
   // Core sequencing
   input  wire                CORE_BOUNDARY_IN,
   input  wire                RETURN_ISR_IN,
   input  wire [PC_WIDTH-1:0] CORE_PC_IN,
   output reg                 IRQ_REQ_OUT,
   output reg                 FLUSH_OUT,
   output reg                 STACK_PUSH_OUT,
   output reg  [PC_WIDTH-1:0] STACK_PC_OUT,
   output reg                 STACK_POP_OUT,
   output reg                 PC_LOAD_OUT,
   output reg  [PC_WIDTH-1:0] PC_VALUE_OUT,
   output reg                 RESTORE_OUT,
   // Live context from the core
   input  wire [7:0]          CTX_W_IN,
   input  wire [7:0]          CTX_STATUS_IN,
   input  wire [7:0]          CTX_BANK_IN,
   input  wire [7:0]          CTX_FSR_LO_IN,
   input  wire [7:0]          CTX_FSR_HI_IN,
   input  wire [7:0]          CTX_PCLATCH_IN,
   // Restore values to the core
   output wire [7:0]          CTX_W_OUT,
   output wire [7:0]          CTX_STATUS_OUT,
   output wire [7:0]          CTX_BANK_OUT,
   output wire [7:0]          CTX_FSR_LO_OUT,
   output wire [7:0]          CTX_FSR_HI_OUT,
   output wire [7:0]          CTX_PCLATCH_OUT
);

   localparam ST_IDLE = 2'b00;
   localparam ST_VEC  = 2'b01;
   localparam ST_ISR  = 2'b10;

   reg  [1:0] state;
   reg  [7:0] irq_control;
   reg  [7:0] periph_enable_one;
   reg        ext_edge_select;
   reg  [7:0] shadow [0:`ICS_SHADOW_COUNT-1];
   wire       ext_edge;
   wire [7:0] ctx_live [0:`ICS_SHADOW_COUNT-1];
   wire       apb_setup;
   wire       apb_commit;
   wire       apb_wr;
   wire       core_hit;
   wire       periph_hit;
   wire       irq_req;
   wire       accept;
   wire       wr_ctl;
   wire       t0_clear;
   wire       ext_clear;
   integer    i;

   // Maps a byte address to a shadow slot; out of range gives all ones.
   function [2:0] shadow_slot;
      input [7:0] addr;
      reg   [7:0] rel;
      begin
         rel = addr - `ICS_OFF_SHADOW_BASE;
         if (addr >= `ICS_OFF_SHADOW_BASE && rel[7:2] < `ICS_SHADOW_COUNT &&
             rel[1:0] == 2'b00) begin
            shadow_slot = rel[4:2];
         end else begin
            shadow_slot = 3'h7;
         end
      end
   endfunction

   // True when the address is one of the mapped words.
   function mapped;
      input [7:0] addr;
      begin
         mapped = (addr == `ICS_OFF_IRQ_CONTROL) ||
                  (addr == `ICS_OFF_PERIPH_EN_ONE) ||
                  (addr == `ICS_OFF_CONFIG) ||
                  (addr == `ICS_OFF_STATE) ||
                  (shadow_slot(addr) != 3'h7);
      end
   endfunction

   ics_edge_det u_edge (
      .clk_in    (CLK_IN),
      .rst_in    (SYS_RST_IN),
      .ce_in     (CE_IN),
      .pin_in    (EXT_PIN_IN),
      .rising_in (ext_edge_select),
      .edge_out  (ext_edge)
   );

   assign ctx_live[`ICS_SH_W]       = CTX_W_IN;
   assign ctx_live[`ICS_SH_STATUS]  = CTX_STATUS_IN & `ICS_STATUS_SAVE_MASK;
   assign ctx_live[`ICS_SH_BANK]    = CTX_BANK_IN;
   assign ctx_live[`ICS_SH_FSR_LO]  = CTX_FSR_LO_IN;
   assign ctx_live[`ICS_SH_FSR_HI]  = CTX_FSR_HI_IN;
   assign ctx_live[`ICS_SH_PCLATCH] = CTX_PCLATCH_IN;

   // The shadow flops drive the core directly, so restore needs no extra stage.
   assign CTX_W_OUT       = shadow[`ICS_SH_W];
   assign CTX_STATUS_OUT  = shadow[`ICS_SH_STATUS];
   assign CTX_BANK_OUT    = shadow[`ICS_SH_BANK];
   assign CTX_FSR_LO_OUT  = shadow[`ICS_SH_FSR_LO];
   assign CTX_FSR_HI_OUT  = shadow[`ICS_SH_FSR_HI];
   assign CTX_PCLATCH_OUT = shadow[`ICS_SH_PCLATCH];

   // Bus phases. Ready is registered in the setup cycle, so every access completes with no wait state.
   assign apb_setup  = PSEL_IN & ~PENABLE_IN;
   assign apb_commit = PSEL_IN & PENABLE_IN & PREADY_OUT;
   assign apb_wr     = apb_commit & PWRITE_IN & ~PSLVERR_OUT;
   assign wr_ctl     = apb_wr & (PADDR_IN == `ICS_OFF_IRQ_CONTROL);

   // A flag written to zero in the same cycle as its event stays set.
   assign t0_clear  = wr_ctl & ~PWDATA_IN[`ICS_T0IF_BIT];
   assign ext_clear = wr_ctl & ~PWDATA_IN[`ICS_EXTIF_BIT];

   assign core_hit =
      (irq_control[`ICS_T0IF_BIT]  & irq_control[`ICS_T0IE_BIT]) |
      (irq_control[`ICS_EXTIF_BIT] & irq_control[`ICS_EXTIE_BIT]) |
      (irq_control[`ICS_PCIF_BIT]  & irq_control[`ICS_PCIE_BIT]);

   // Each enable bit of periph_enable_one pairs with the flag in the same bit.
   assign periph_hit = irq_control[`ICS_PERIPH_IRQ_ENABLE_BIT] &
                       (|(PERIPH_FLAGS_IN & periph_enable_one));

   assign irq_req = irq_control[`ICS_GIE_BIT] & (core_hit | periph_hit);

   // Entry is only taken from idle; a handler that re-enables interrupts
   // must return before a second entry can be accepted.
   assign accept = (state == ST_IDLE) & CORE_BOUNDARY_IN & irq_req;

   // irq_control and configuration.
   always @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         irq_control     <= `ICS_RST_IRQ_CONTROL;
         ext_edge_select <= 1'b0;
      end else if (CE_IN) begin
         if (wr_ctl) begin
            irq_control[7:3] <= PWDATA_IN[7:3];
         end
         if (accept) begin
            irq_control[`ICS_GIE_BIT] <= 1'b0;
         end else if (state == ST_ISR && RETURN_ISR_IN) begin
            irq_control[`ICS_GIE_BIT] <= 1'b1;
         end
         if (TIMER0_COUNT_OVF_IN) begin
            irq_control[`ICS_T0IF_BIT] <= 1'b1;
         end else if (t0_clear) begin
            irq_control[`ICS_T0IF_BIT] <= 1'b0;
         end
         if (ext_edge) begin
            irq_control[`ICS_EXTIF_BIT] <= 1'b1;
         end else if (ext_clear) begin
            irq_control[`ICS_EXTIF_BIT] <= 1'b0;
         end
         // Follows the OR of the change flags; bus writes never touch it.
         irq_control[`ICS_PCIF_BIT] <= PIN_CHANGE_ANY_IN;
         if (apb_wr && PADDR_IN == `ICS_OFF_CONFIG) begin
            ext_edge_select <= PWDATA_IN[0];
         end
      end
   end

   // periph_enable_one: plain read/write.
   always @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         periph_enable_one <= `ICS_RST_PERIPH_EN_ONE;
      end else if (CE_IN) begin
         if (apb_wr && PADDR_IN == `ICS_OFF_PERIPH_EN_ONE) begin
            periph_enable_one <= PWDATA_IN[7:0];
         end
      end
   end

   // Shadow copies. Entry capture wins over a bus write in the same cycle.
   always @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         for (i = 0; i < `ICS_SHADOW_COUNT; i = i + 1) begin
            shadow[i] <= 8'h00;
         end
      end else if (CE_IN) begin
         if (accept) begin
            for (i = 0; i < `ICS_SHADOW_COUNT; i = i + 1) begin
               shadow[i] <= ctx_live[i];
            end
         end else if (apb_wr && shadow_slot(PADDR_IN) != 3'h7) begin
            if (shadow_slot(PADDR_IN) == `ICS_SH_STATUS) begin
               shadow[`ICS_SH_STATUS] <= PWDATA_IN[7:0] & `ICS_STATUS_SAVE_MASK;
            end else begin
               shadow[shadow_slot(PADDR_IN)] <= PWDATA_IN[7:0];
            end
         end
      end
   end

   // Core sequencing: push and capture, then vector load, then service.
   always @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         state          <= ST_IDLE;
         IRQ_REQ_OUT    <= 1'b0;
         FLUSH_OUT      <= 1'b0;
         STACK_PUSH_OUT <= 1'b0;
         STACK_PC_OUT   <= {PC_WIDTH{1'b0}};
         STACK_POP_OUT  <= 1'b0;
         PC_LOAD_OUT    <= 1'b0;
         PC_VALUE_OUT   <= {PC_WIDTH{1'b0}};
         RESTORE_OUT    <= 1'b0;
      end else if (CE_IN) begin
         IRQ_REQ_OUT    <= irq_req;
         FLUSH_OUT      <= 1'b0;
         STACK_PUSH_OUT <= 1'b0;
         STACK_POP_OUT  <= 1'b0;
         PC_LOAD_OUT    <= 1'b0;
         RESTORE_OUT    <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (accept) begin
                  FLUSH_OUT      <= 1'b1;
                  STACK_PUSH_OUT <= 1'b1;
                  STACK_PC_OUT   <= CORE_PC_IN;
                  state          <= ST_VEC;
               end
            end
            ST_VEC: begin
               // One cycle after the push, so the stack holds the return PC.
               PC_LOAD_OUT  <= 1'b1;
               PC_VALUE_OUT <= `ICS_VECTOR;
               state        <= ST_ISR;
            end
            ST_ISR: begin
               if (RETURN_ISR_IN) begin
                  STACK_POP_OUT <= 1'b1;
                  RESTORE_OUT   <= 1'b1;
                  state         <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // APB slave: ready and read data are registered in the setup cycle.
   always @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         PREADY_OUT  <= 1'b0;
         PRDATA_OUT  <= 32'h00000000;
         PSLVERR_OUT <= 1'b0;
      end else if (CE_IN) begin
         PREADY_OUT  <= apb_setup;
         PSLVERR_OUT <= apb_setup & ~mapped(PADDR_IN);
         if (apb_setup && !PWRITE_IN) begin
            if (PADDR_IN == `ICS_OFF_IRQ_CONTROL) begin
               PRDATA_OUT <= {24'h000000, irq_control};
            end else if (PADDR_IN == `ICS_OFF_PERIPH_EN_ONE) begin
               PRDATA_OUT <= {24'h000000, periph_enable_one};
            end else if (PADDR_IN == `ICS_OFF_CONFIG) begin
               PRDATA_OUT <= {31'h00000000, ext_edge_select};
            end else if (PADDR_IN == `ICS_OFF_STATE) begin
               PRDATA_OUT <= {29'h00000000, irq_req, state};
            end else if (shadow_slot(PADDR_IN) != 3'h7) begin
               PRDATA_OUT <= {24'h000000, shadow[shadow_slot(PADDR_IN)]};
            end else begin
               PRDATA_OUT <= 32'h00000000;
            end
         end else begin
            PRDATA_OUT <= 32'h00000000;
         end
      end
   end

endmodule

// file: tb/ics_core_model.sv
// Purpose: Behavioural processor core facing the interrupt block.
// Assumes: Service routine trashes live context; return reloads it.
// Notes:   Live TO/PD bits survive a restore, as the core keeps them.
`timescale 1ns/1ns
module ics_core_model (
   // Clock and reset
   input  wire        clk_in,
   input  wire        rst_in,
   // Sequencing from the block
   input  wire        push_in,
   input  wire        load_in,
   input  wire        restore_in,
   input  wire [7:0]  w_sh_in,
   input  wire [7:0]  st_sh_in,
   // Core state
   output reg  [14:0] pc_out,
   output reg  [7:0]  w_out,
   output reg  [7:0]  st_out,
   output wire        boundary_out
);
   reg in_isr;
   assign boundary_out = ~in_isr;
   always @(posedge clk_in) begin
      if (rst_in) begin
         pc_out <= 15'h0100;
         w_out <= 8'h3C;
         st_out <= 8'hFF;
         in_isr <= 1'b0;
      end else begin
         pc_out <= pc_out + 15'h0001;
         if (push_in) in_isr <= 1'b1;
         // The routine overwrites live registers so a missing restore shows.
         if (load_in) begin
            w_out <= ~w_out;
            st_out <= st_out & 8'h18;
         end
         if (restore_in) begin
            w_out <= w_sh_in;
            st_out <= {st_sh_in[7:5], st_out[4:3], st_sh_in[2:0]};
            in_isr <= 1'b0;
         end
      end
   end
endmodule

// file: tb/ics_ctrl_monitor.sv
// Purpose: Port-level checks of the interrupt block.
// Assumes: CE_IN held high.
// Notes:   Bound into every instance of the block.
`timescale 1ns/1ns
`include "ics_consts.vh"
module ics_ctrl_monitor #(
   parameter PC_WIDTH = 15
) (
   input wire                CLK_IN, SYS_RST_IN, PSEL_IN, PENABLE_IN, PREADY_OUT,
   input wire                PSLVERR_OUT, RETURN_ISR_IN, FLUSH_OUT, STACK_PUSH_OUT,
   input wire                STACK_POP_OUT, PC_LOAD_OUT, RESTORE_OUT,
   input wire [31:0]         PRDATA_OUT,
   input wire [PC_WIDTH-1:0] CORE_PC_IN, STACK_PC_OUT, PC_VALUE_OUT,
   input wire [7:0]          CTX_W_IN, CTX_STATUS_IN, CTX_W_OUT, CTX_STATUS_OUT
);
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   push_flush_a: assert property (STACK_PUSH_OUT |-> FLUSH_OUT)
      else $error("Push without flush.");
   vec_load_a: assert property (STACK_PUSH_OUT |=> PC_LOAD_OUT && PC_VALUE_OUT == 4)
      else $error("Vector load missing or wrong.");
   load_order_a: assert property (PC_LOAD_OUT |-> $past(STACK_PUSH_OUT))
      else $error("Vector load without preceding push.");
   push_pc_a: assert property (STACK_PUSH_OUT |-> STACK_PC_OUT == $past(CORE_PC_IN))
      else $error("Pushed PC differs.");
   save_ctx_a: assert property (STACK_PUSH_OUT |-> CTX_W_OUT == $past(CTX_W_IN)
      && CTX_STATUS_OUT == ($past(CTX_STATUS_IN) & `ICS_STATUS_SAVE_MASK))
      else $error("Context not saved.");
   pop_cause_a: assert property (STACK_POP_OUT |-> RESTORE_OUT && $past(RETURN_ISR_IN))
      else $error("Pop without return or restore.");
   apb_ready_a: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
      else $error("No answer after setup.");
   ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
      else $error("Ready held too long.");
   idle_bus_a: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0 && !PSLVERR_OUT)
      else $error("Read data or error outside access.");
   cover property (STACK_PUSH_OUT);
   cover property (STACK_POP_OUT);
   cover property (PSLVERR_OUT);
endmodule
bind ics_ctrl ics_ctrl_monitor #(.PC_WIDTH(PC_WIDTH)) ics_ctrl_monitor_inst (
   .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
   .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .RETURN_ISR_IN(RETURN_ISR_IN),
   .FLUSH_OUT(FLUSH_OUT), .STACK_PUSH_OUT(STACK_PUSH_OUT), .STACK_POP_OUT(STACK_POP_OUT),
   .PC_LOAD_OUT(PC_LOAD_OUT), .RESTORE_OUT(RESTORE_OUT), .PRDATA_OUT(PRDATA_OUT),
   .CORE_PC_IN(CORE_PC_IN), .STACK_PC_OUT(STACK_PC_OUT), .PC_VALUE_OUT(PC_VALUE_OUT),
   .CTX_W_IN(CTX_W_IN), .CTX_STATUS_IN(CTX_STATUS_IN), .CTX_W_OUT(CTX_W_OUT),
   .CTX_STATUS_OUT(CTX_STATUS_OUT));

// file: tb/ics_ctrl_test.sv
// Purpose: Self-checking bench for the interrupt block.
// Assumes: APB answers in one access cycle; CE_IN tied high.
// Notes:   Each service call runs one full entry and return.
`timescale 1ns/1ns
`include "ics_consts.vh"
module ics_ctrl_test;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic        t0 = 1'b0, pin = 1'b0, pchg = 1'b0, ret = 1'b0;
   logic        pready, perr, req, flush, push, pop, pload, rstore, bnd;
   logic [7:0]  paddr = 8'h00, pflags = 8'h00, cw, cst, ow, ost, ob, ofl, ofh, opl;
   logic [7:0]  exp_w = 8'h3C;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [14:0] cpc, spc, pcv;
   int          bad_count = 0, tests_run = 0, cycles = 0, pushes = 0;
   always #5 clk = ~clk;
   ics_ctrl ics_ctrl_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .CE_IN(1'b1), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(perr), .TIMER0_COUNT_OVF_IN(t0),
      .EXT_PIN_IN(pin), .PIN_CHANGE_ANY_IN(pchg), .PERIPH_FLAGS_IN(pflags),
      .CORE_BOUNDARY_IN(bnd), .RETURN_ISR_IN(ret), .CORE_PC_IN(cpc), .IRQ_REQ_OUT(req),
      .FLUSH_OUT(flush), .STACK_PUSH_OUT(push), .STACK_PC_OUT(spc), .STACK_POP_OUT(pop),
      .PC_LOAD_OUT(pload), .PC_VALUE_OUT(pcv), .RESTORE_OUT(rstore), .CTX_W_IN(cw),
      .CTX_STATUS_IN(cst), .CTX_BANK_IN(cw + 8'h01), .CTX_FSR_LO_IN(cw + 8'h02),
      .CTX_FSR_HI_IN(cw + 8'h03), .CTX_PCLATCH_IN(cw + 8'h04), .CTX_W_OUT(ow),
      .CTX_STATUS_OUT(ost), .CTX_BANK_OUT(ob), .CTX_FSR_LO_OUT(ofl),
      .CTX_FSR_HI_OUT(ofh), .CTX_PCLATCH_OUT(opl));
   ics_core_model ics_core_model_inst (.clk_in(clk), .rst_in(rst), .push_in(push),
      .load_in(pload), .restore_in(rstore), .w_sh_in(ow), .st_sh_in(ost), .pc_out(cpc),
      .w_out(cw), .st_out(cst), .boundary_out(bnd));
   task tally_and_finish;
      $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (push === 1'b1) pushes <= pushes + 1;
      // Ceiling sits far above the few hundred cycles the sequence needs.
      if (cycles == 8000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Waits for ready as long as it takes; only the cycle ceiling ends a hang.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      cmp(r, x);
   endtask
   task no_entry;
      int c;
      c = pushes;
      repeat (8) @(posedge clk);
      cmp(pushes, c);
      cmp(req, 1'b0);
   endtask
   task service(input logic [7:0] nw);
      int n;
      logic [31:0] r;
      logic e;
      n = 0;
      while (push !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      cmp(push, 1'b1);
      @(posedge clk);
      cmp(pload, 1'b1);
      cmp(pcv, `ICS_VECTOR);
      pflags <= 8'h00;
      pchg <= 1'b0;
      apb(1'b0, 8'h00, 32'h0, r, e);
      cmp(r[7], 1'b0);
      rd(8'h20, exp_w);
      rd(8'h24, 8'hE7);
      rd(8'h28, exp_w + 8'h01);
      wr(8'h20, nw);
      wr(8'h00, 8'h38);
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      n = 0;
      while (pop !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      cmp(rstore, 1'b1);
      @(posedge clk);
      cmp(cw, nw);
      cmp(cst, 8'hFF);
      exp_w = nw;
      apb(1'b0, 8'h00, 32'h0, r, e);
      cmp(r[7], 1'b1);
   endtask
   task t_regs;
      logic [31:0] r;
      logic e;
      rd(8'h00, 8'h00);
      rd(8'h04, 8'h00);
      wr(8'h04, 8'hFF);
      rd(8'h04, 8'hFF);
      wr(8'h04, 8'h5A);
      rd(8'h04, 8'h5A);
      wr(8'h00, 8'h79);
      rd(8'h00, 8'h78);
      wr(8'h00, 8'h00);
      apb(1'b0, 8'h40, 32'h0, r, e);
      cmp(e, 1'b1);
      cmp(r, 32'h0);
   endtask
   task t_flags;
      t0 <= 1'b1;
      @(posedge clk);
      t0 <= 1'b0;
      pchg <= 1'b1;
      repeat (2) @(posedge clk);
      rd(8'h00, 8'h05);
      wr(8'h00, 8'h00);
      rd(8'h00, 8'h01);
      pchg <= 1'b0;
      repeat (2) @(posedge clk);
      rd(8'h00, 8'h00);
   endtask
   task t_periph;
      logic [7:0] b;
      wr(8'h04, 8'hFF);
      pflags <= 8'hFF;
      wr(8'h00, 8'h80);
      no_entry();
      wr(8'h00, 8'h40);
      no_entry();
      for (int k = 0; k < 8; k++) begin
         b = 8'h01 << k;
         wr(8'h04, b);
         pflags <= ~b;
         wr(8'h00, 8'hC0);
         no_entry();
         pflags <= 8'hFF;
         service(8'h40 + k);
      end
   endtask
   task t_core;
      wr(8'h00, 8'h98);
      t0 <= 1'b1;
      @(posedge clk);
      t0 <= 1'b0;
      no_entry();
      wr(8'h00, 8'hA4);
      service(8'h55);
      wr(8'h08, 8'h01);
      wr(8'h00, 8'h90);
      pin <= 1'b1;
      service(8'h66);
      pin <= 1'b0;
      no_entry();
      wr(8'h08, 8'h00);
      pin <= 1'b1;
      no_entry();
      pin <= 1'b0;
      service(8'h77);
      pchg <= 1'b1;
      service(8'h3C);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_flags();
      t_periph();
      t_core();
      tally_and_finish();
   end
endmodule
